/* File: sartb_sequencer.sv */
/*
 * sar converter track and burst sequencer with axi4-lite registers.
 * assumes the analog comparator output is valid one conversion tick after
 * a new trial code, and that the burst oscillator arrives as a one-cycle
 * enable pulse synchronous to aclk.
 */
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sartb_sequencer #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic burst_osc_tick,
  input wire logic timer0_overflow,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic external_start_pin,
  input wire logic standby_sleep,
  input wire logic sar_compare,
  output logic [9:0] sar_trial,
  output logic track_enable,
  output logic power_on,
  output logic gain_half,
  output logic convert_active
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic converter_enable;
  logic burst_mode_enable;
  logic end_of_conversion_flag;
  logic window_compare_flag;
  logic [2:0] start_source_select;
  logic [4:0] conversion_clock_divider;
  logic eight_bit_mode_enable;
  logic low_power_track_select;
  logic gain_select;
  logic [3:0] power_up_time_setting;
  logic [3:0] burst_track_time_setting;
  logic [2:0] repeat_code;
  logic [15:0] result;
  logic [15:0] thresh_greater;
  logic [15:0] thresh_less;
  sartb_pkg::sartb_state_t state;
  logic [4:0] div_cnt;
  logic [4:0] wait_left;
  logic [3:0] bit_idx;
  logic [9:0] sar_code;
  logic [15:0] acc;
  logic [6:0] conv_cnt;
  logic pin_prev;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // ************************************************************
  // combinational terms
  // ************************************************************
  logic do_write;
  logic wr_control;
  logic wr_config;
  logic wr_timing;
  logic wr_greater;
  logic wr_less;
  logic map_hit_w;
  logic pin_rise;
  logic start_req;
  logic conv_tick;
  logic bit_done;
  logic [9:0] next_code;
  logic [15:0] next_acc;
  logic last_conv;
  logic [4:0] burst_track_len;
  logic [3:0] low_bit;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a[7:0] == ofs);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = m;
  endfunction : merge

  // merged words are staged here, a call result cannot be part-selected
  logic [31:0] timing_word;
  logic [31:0] greater_word;
  logic [31:0] less_word;
  assign timing_word = merge({21'h000000, repeat_code,
    burst_track_time_setting, power_up_time_setting}, w_data, w_strb);
  assign greater_word = merge({16'h0000, thresh_greater}, w_data, w_strb);
  assign less_word = merge({16'h0000, thresh_less}, w_data, w_strb);

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_control = do_write && hit(aw_addr, sartb_pkg::OFS_CONTROL)
    && w_strb[0];
  assign wr_config = do_write && hit(aw_addr, sartb_pkg::OFS_CONFIG);
  assign wr_timing = do_write && hit(aw_addr, sartb_pkg::OFS_TIMING);
  assign wr_greater = do_write && hit(aw_addr, sartb_pkg::OFS_GREATER);
  assign wr_less = do_write && hit(aw_addr, sartb_pkg::OFS_LESS);
  assign map_hit_w = hit(aw_addr, sartb_pkg::OFS_CONTROL)
    || hit(aw_addr, sartb_pkg::OFS_CONFIG)
    || hit(aw_addr, sartb_pkg::OFS_TIMING)
    || hit(aw_addr, sartb_pkg::OFS_RESULT)
    || hit(aw_addr, sartb_pkg::OFS_GREATER)
    || hit(aw_addr, sartb_pkg::OFS_LESS);

  assign pin_rise = external_start_pin && !pin_prev;
  always_comb
  begin
    case (start_source_select)
      sartb_pkg::SRC_SOFTWARE:
        start_req = wr_control && s_axi_wdata_busy(w_data);
      sartb_pkg::SRC_TIMER0: start_req = timer0_overflow;
      sartb_pkg::SRC_TIMER2: start_req = timer2_overflow;
      sartb_pkg::SRC_TIMER3: start_req = timer3_overflow;
      default: start_req = pin_rise;
    endcase
  end

  function automatic logic s_axi_wdata_busy(input logic [31:0] d);
    s_axi_wdata_busy = d[sartb_pkg::CTL_BUSY];
  endfunction : s_axi_wdata_busy

  // one-cycle conversion tick; burst mode divides the burst oscillator
  assign conv_tick = (burst_mode_enable ? burst_osc_tick : 1'b1)
    && (div_cnt == conversion_clock_divider);
  assign low_bit = eight_bit_mode_enable ? sartb_pkg::SAR_LOW_BIT_8
    : sartb_pkg::SAR_LOW_BIT_10;
  assign bit_done = (state == sartb_pkg::ST_CONVERT) && conv_tick;
  assign next_code = sar_compare ? sar_trial : sar_code;
  assign next_acc = acc + {6'h00, next_code};
  assign last_conv = (conv_cnt + 7'h01)
    == sartb_pkg::repeat_count(repeat_code);
  // low-power tracking stacks 3 extra ticks on the track setting
  assign burst_track_len = {1'b0, burst_track_time_setting}
    + (low_power_track_select ? sartb_pkg::LP_TRACK_TICKS : 5'h00);

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= map_hit_w ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      if (hit(s_axi_araddr, sartb_pkg::OFS_CONTROL))
        s_axi_rdata[7:0] <= {converter_enable, burst_mode_enable,
          end_of_conversion_flag, state != sartb_pkg::ST_IDLE,
          window_compare_flag, start_source_select};
      else if (hit(s_axi_araddr, sartb_pkg::OFS_CONFIG))
        s_axi_rdata[7:0] <= {conversion_clock_divider,
          eight_bit_mode_enable, low_power_track_select, gain_select};
      else if (hit(s_axi_araddr, sartb_pkg::OFS_TIMING))
        s_axi_rdata[10:0] <= {repeat_code, burst_track_time_setting,
          power_up_time_setting};
      else if (hit(s_axi_araddr, sartb_pkg::OFS_RESULT))
        s_axi_rdata[15:0] <= result;
      else if (hit(s_axi_araddr, sartb_pkg::OFS_GREATER))
        s_axi_rdata[15:0] <= thresh_greater;
      else if (hit(s_axi_araddr, sartb_pkg::OFS_LESS))
        s_axi_rdata[15:0] <= thresh_less;
      else
        s_axi_rresp <= 2'h2;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // software settings
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      converter_enable <= 1'b0;
      burst_mode_enable <= 1'b0;
      start_source_select <= sartb_pkg::SRC_SOFTWARE;
      conversion_clock_divider <= 5'h1F;
      eight_bit_mode_enable <= 1'b0;
      low_power_track_select <= 1'b0;
      gain_select <= 1'b0;
      {repeat_code, burst_track_time_setting, power_up_time_setting}
        <= sartb_pkg::TIMING_RESET[10:0];
      thresh_greater <= 16'h0000;
      thresh_less <= sartb_pkg::THRESH_LESS_RESET[15:0];
    end
    else
    begin
      if (wr_control)
      begin
        converter_enable <= w_data[sartb_pkg::CTL_ENABLE];
        burst_mode_enable <= w_data[sartb_pkg::CTL_BURST];
        start_source_select <= w_data[sartb_pkg::CTL_SRC_LSB +: 3];
      end
      if (wr_config && w_strb[0])
      begin
        conversion_clock_divider <= w_data[sartb_pkg::CFG_DIV_LSB +: 5];
        eight_bit_mode_enable <= w_data[sartb_pkg::CFG_EIGHT];
        low_power_track_select <= w_data[sartb_pkg::CFG_LPTRACK];
        gain_select <= w_data[sartb_pkg::CFG_GAIN];
      end
      if (wr_timing)
        {repeat_code, burst_track_time_setting, power_up_time_setting}
          <= timing_word[10:0];
      if (wr_greater)
        thresh_greater <= greater_word[15:0];
      if (wr_less)
        thresh_less <= less_word[15:0];
    end
  end

  // ************************************************************
  // conversion clock divider and pin edge
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= 5'h00;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_prev <= external_start_pin;
      if (conv_tick)
        div_cnt <= 5'h00;
      else if (!burst_mode_enable || burst_osc_tick)
        div_cnt <= div_cnt + 5'h01;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= sartb_pkg::ST_IDLE;
      wait_left <= 5'h00;
      bit_idx <= sartb_pkg::SAR_TOP_BIT;
      sar_code <= 10'h000;
      sar_trial <= 10'h000;
      acc <= 16'h0000;
      conv_cnt <= 7'h00;
      result <= 16'h0000;
    end
    else
    begin
      case (state)
        sartb_pkg::ST_IDLE:
          // starts only land here, so a running series is never restarted
          if (start_req && (converter_enable || burst_mode_enable))
          begin
            if (burst_mode_enable && !converter_enable)
            begin
              state <= sartb_pkg::ST_POWERUP;
              wait_left <= {1'b0, power_up_time_setting};
            end
            else if (burst_mode_enable)
            begin
              state <= sartb_pkg::ST_TRACK;
              wait_left <= burst_track_len;
            end
            else if (low_power_track_select
                     && start_source_select[2])
            begin
              // the pin was low while tracking; its rise starts the hold
              state <= sartb_pkg::ST_CONVERT;
            end
            else if (low_power_track_select)
            begin
              state <= sartb_pkg::ST_TRACK;
              wait_left <= sartb_pkg::LP_TRACK_TICKS;
            end
            else
            begin
              state <= sartb_pkg::ST_CONVERT;
            end
            bit_idx <= sartb_pkg::SAR_TOP_BIT;
            sar_code <= 10'h000;
            sar_trial <= 10'h200;
          end
        sartb_pkg::ST_POWERUP:
          if (wait_left == 5'h00)
          begin
            state <= sartb_pkg::ST_TRACK;
            wait_left <= burst_track_len;
          end
          else if (conv_tick)
            wait_left <= wait_left - 5'h01;
        sartb_pkg::ST_TRACK:
          if (wait_left == 5'h00)
            state <= sartb_pkg::ST_CONVERT;
          else if (conv_tick)
            wait_left <= wait_left - 5'h01;
        sartb_pkg::ST_CONVERT:
          if (bit_done)
          begin
            sar_code <= next_code;
            // one tick per bit; 8-bit mode stops two bits early
            if (bit_idx == low_bit)
            begin
              sar_trial <= next_code;
              if (last_conv)
              begin
                result <= next_acc;
                acc <= 16'h0000;
                conv_cnt <= 7'h00;
                state <= sartb_pkg::ST_IDLE;
              end
              else
              begin
                acc <= next_acc;
                conv_cnt <= conv_cnt + 7'h01;
                if (burst_mode_enable && !start_source_select[2])
                begin
                  state <= sartb_pkg::ST_TRACK;
                  wait_left <= burst_track_len;
                  bit_idx <= sartb_pkg::SAR_TOP_BIT;
                  sar_code <= 10'h000;
                  sar_trial <= 10'h200;
                end
                else
                  state <= sartb_pkg::ST_IDLE;
              end
            end
            else
            begin
              bit_idx <= bit_idx - 4'h1;
              sar_trial <= next_code | (10'h001 << (bit_idx - 4'h1));
            end
          end
        default: state <= sartb_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // flags: a hardware set beats a software clear in the same cycle
  // ************************************************************
  logic series_done;
  logic window_hit;
  assign series_done = bit_done && (bit_idx == low_bit) && last_conv;
  assign window_hit = (next_acc > thresh_greater)
    && (next_acc < thresh_less);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      end_of_conversion_flag <= 1'b0;
      window_compare_flag <= 1'b0;
    end
    else
    begin
      if (series_done)
        end_of_conversion_flag <= 1'b1;
      else if (wr_control)
        end_of_conversion_flag <= w_data[sartb_pkg::CTL_EOC];
      if (series_done && window_hit)
        window_compare_flag <= 1'b1;
      else if (wr_control)
        window_compare_flag <= w_data[sartb_pkg::CTL_WINDOW];
    end
  end

  // ************************************************************
  // analog controls
  // ************************************************************
  always_comb
  begin
    if (standby_sleep)
      track_enable = 1'b0;
    else if (burst_mode_enable)
      track_enable = (state == sartb_pkg::ST_TRACK);
    else if (low_power_track_select && start_source_select[2])
      track_enable = converter_enable && !external_start_pin
        && (state == sartb_pkg::ST_IDLE);
    else if (low_power_track_select)
      track_enable = (state == sartb_pkg::ST_TRACK);
    else
      track_enable = converter_enable
        && (state != sartb_pkg::ST_CONVERT);
  end
  // burst with enable low powers down in idle, so only wakes on a start
  assign power_on = converter_enable
    || (burst_mode_enable && state != sartb_pkg::ST_IDLE);
  assign gain_half = gain_select;
  assign convert_active = (state == sartb_pkg::ST_CONVERT);
endmodule : sartb_sequencer
`default_nettype wire

/* File: sartb_pkg.sv */
/*
 * constants, register layout and decode helpers for the sar converter
 * track and burst sequencer.
 * assumes one 100 MHz bus clock and 32-bit axi4-lite register access.
 */
package sartb_pkg;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_GREATER = 8'h10;
  localparam logic [7:0] OFS_LESS = 8'h14;
  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_BURST = 6;
  localparam int CTL_EOC = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_WINDOW = 3;
  localparam int CTL_SRC_LSB = 0;
  // ************************************************************
  // config register fields
  // ************************************************************
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_EIGHT = 2;
  localparam int CFG_LPTRACK = 1;
  localparam int CFG_GAIN = 0;
  // ************************************************************
  // timing register fields
  // ************************************************************
  localparam int TIM_PWR_LSB = 0;
  localparam int TIM_TRK_LSB = 4;
  localparam int TIM_RPT_LSB = 8;
  localparam logic [31:0] TIMING_RESET = 32'h00000022;
  localparam logic [31:0] THRESH_LESS_RESET = 32'h0000FFFF;
  // ************************************************************
  // start sources and timing
  // ************************************************************
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_TIMER2 = 3'h2;
  localparam logic [2:0] SRC_TIMER3 = 3'h3;
  localparam logic [4:0] LP_TRACK_TICKS = 5'h03;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  localparam logic [3:0] SAR_LOW_BIT_8 = 4'h2;
  localparam logic [3:0] SAR_LOW_BIT_10 = 4'h0;
  localparam int BURST_CLOCK_MHZ = 20;
  typedef enum {ST_IDLE, ST_POWERUP, ST_TRACK, ST_CONVERT} sartb_state_t;
  // repeat count code: 0 1x, 1 4x, 2 8x, 3 16x, 4 32x, others 64x
  function automatic logic [6:0] repeat_count(input logic [2:0] code);
    case (code)
      3'h0: repeat_count = 7'h01;
      3'h1: repeat_count = 7'h04;
      3'h2: repeat_count = 7'h08;
      3'h3: repeat_count = 7'h10;
      3'h4: repeat_count = 7'h20;
      default: repeat_count = 7'h40;
    endcase
  endfunction : repeat_count
endpackage : sartb_pkg

/* File: sartb_seq_props.sv */
/* assertions on the ports of the sar track and burst sequencer.
   assumes a bind into every sartb_sequencer, single clock aclk. */
`timescale 1ns/1ps
`default_nettype none
module sartb_seq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic standby_sleep,
  input wire logic track_enable,
  input wire logic power_on,
  input wire logic convert_active
);
  // ********************************
  // port relations
  // ********************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_sleep; standby_sleep |-> !track_enable; endproperty
  a_sleep: assert property (p_sleep) else $error("track in sleep");
  property p_conv; convert_active |-> !track_enable; endproperty
  a_conv: assert property (p_conv) else $error("track in convert");
  // 8-bit mode is the shortest case, one aclk per tick at least
  property p_len; $rose(convert_active) |-> convert_active[*8]; endproperty
  a_len: assert property (p_len) else $error("convert too short");
  property p_pwr; (track_enable || convert_active) |-> power_on; endproperty
  a_pwr: assert property (p_pwr) else $error("work while off");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bblk: assert property (p_bblk) else $error("write ready early");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read ready early");
endmodule : sartb_seq_props
bind sartb_sequencer sartb_seq_props u_props (.aclk, .aresetn,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .standby_sleep, .track_enable, .power_on, .convert_active);
`default_nettype wire

/* File: sartb_sequencer_tb.sv */
/* self-checking bench for the sar track and burst sequencer.
   assumes an ideal comparator and the burst tick every other cycle. */
`timescale 1ns/1ps
`default_nettype none
module sartb_sequencer_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, track_enable, power_on, gain_half, convert_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic burst_osc_tick = 0, external_start_pin = 0, standby_sleep = 0;
  logic [2:0] tmr = 0;
  logic [9:0] sar_trial;
  logic [9:0] vin = 10'h2A5;
  wire logic sar_compare = (vin >= sar_trial);
  int err_count = 0, compares = 0, cyc = 0, n, i;
  sartb_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .burst_osc_tick,
    .timer0_overflow(tmr[0]), .timer2_overflow(tmr[1]),
    .timer3_overflow(tmr[2]), .external_start_pin, .standby_sleep,
    .sar_compare, .sar_trial, .track_enable, .power_on, .gain_half,
    .convert_active);
  // ********************************
  // clock, ticks, watchdog
  // ********************************
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    burst_osc_tick <= ~burst_osc_tick;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report;
    end
  end
  // ********************************
  // bus and check tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    // one idle edge so the next call never reassigns bready in this step
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  task automatic waitb(input int b, input logic v);
    n = 0;
    do
    begin
      rd(8'h00);
      n++;
    end while (d[b] !== v && n < 300);
    chk(32'(d[b]), 32'(v));
  endtask : waitb
  task automatic pulse(input int b);
    tmr[b] <= 1;
    @(posedge aclk);
    tmr[b] <= 0;
  endtask : pulse
  // ********************************
  // scenarios
  // ********************************
  task automatic t_single;
    rc(8'h00, 32'h0);
    rc(8'h04, 32'hF8);
    rc(8'h08, 32'h22);
    rc(8'h14, 32'hFFFF);
    rd(8'h18);
    chk(32'(rr), 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h100);
    wr(8'h14, 32'h300);
    wr(8'h00, 32'h80);
    chk(32'(track_enable), 32'h1);
    standby_sleep <= 1;
    @(posedge aclk);
    chk(32'(track_enable), 32'h0);
    standby_sleep <= 0;
    wr(8'h00, 32'h90);
    waitb(5, 1);
    chk(d & 32'h28, 32'h28);
    rc(8'h0C, 32'h2A5);
  endtask : t_single
  task automatic t_modes;
    wr(8'h04, 32'h05);
    chk(32'(gain_half), 32'h1);
    wr(8'h00, 32'h90);
    waitb(5, 1);
    rc(8'h0C, 32'h2A4);
    wr(8'h04, 32'h02);
    chk(32'(track_enable), 32'h0);
    n = 0;
    fork
      wr(8'h00, 32'h90);
      repeat (40)
      begin
        @(posedge aclk);
        if (track_enable && !convert_active) n++;
      end
    join
    chk(32'(n >= 3), 32'h1);
    wr(8'h04, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      wr(8'h00, 32'h80 | 32'(i + 1));
      pulse(i);
      waitb(5, 1);
    end
    wr(8'h04, 32'h02);
    wr(8'h00, 32'h84);
    chk(32'(track_enable), 32'h1);
    external_start_pin <= 1;
    @(posedge aclk);
    chk(32'(track_enable), 32'h0);
    waitb(5, 1);
    rc(8'h0C, 32'h2A5);
    external_start_pin <= 0;
    wr(8'h04, 32'h0);
  endtask : t_modes
  task automatic t_burst;
    wr(8'h08, 32'h122);
    wr(8'h00, 32'h41);
    chk(32'(power_on), 32'h0);
    pulse(0);
    waitb(5, 1);
    rc(8'h0C, 32'hA94);
    chk(32'(power_on), 32'h0);
    wr(8'h00, 32'hC1);
    pulse(0);
    waitb(5, 1);
    chk(32'(power_on), 32'h1);
    wr(8'h00, 32'h44);
    for (i = 0; i < 4; i++)
    begin
      rd(8'h00);
      chk(32'(d[5]), 32'h0);
      external_start_pin <= 1;
      repeat (4) @(posedge aclk);
      external_start_pin <= 0;
      waitb(4, 0);
    end
    waitb(5, 1);
    rc(8'h0C, 32'hA94);
  endtask : t_burst
  task automatic final_report;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_single;
    t_modes;
    t_burst;
    final_report;
  end
endmodule : sartb_sequencer_tb
`default_nettype wire
